// *** status_interrupt_regs_pkg.sv ***
/*
 Register map, field positions, reset values and state layout of the
 user-interface status and interrupt register bank.
 Assumes one clock domain for all logic; pins are synchronised inside the bank.
*/
package status_interrupt_regs_pkg;

	// Register indices; byte address is four times the index
	localparam int unsigned IDX_W = 3;
	localparam logic [2:0] IDX_COMMAND = 3'h0;
	localparam logic [2:0] IDX_DATAPATH_STATE = 3'h1;
	localparam logic [2:0] IDX_FUNCTION = 3'h2;
	localparam logic [2:0] IDX_FLAG_EVENTS = 3'h3;
	localparam logic [2:0] IDX_POLARITY = 3'h4;
	localparam logic [2:0] IDX_BOARD_CFG = 3'h5;
	localparam logic [2:0] IDX_IRQ_STATUS = 3'h6;
	localparam logic [2:0] IDX_IRQ_MASK = 3'h7;

	// Field positions
	localparam int unsigned CMD_IFACE_EN_BIT = 3;
	localparam int unsigned CMD_FLAG_EN_LSB = 4;
	localparam int unsigned DP_OUT_DATA_BIT = 0;
	localparam int unsigned DP_IN_DATA_BIT = 1;
	localparam int unsigned DP_STARVED_BIT = 2;
	localparam int unsigned FN_CODE_MID_BIT = 4;
	localparam int unsigned FN_CODE_HIGH_BIT = 5;
	localparam int unsigned FN_SRC_SEL_BIT = 6;
	localparam int unsigned FN_SYNTH_EN_BIT = 7;
	localparam int unsigned POL_GLOBAL_EN_BIT = 4;
	localparam int unsigned POL_INHIBIT_BIT = 5;
	localparam int unsigned BRD_IRQ_EN_BIT = 0;
	localparam int unsigned IRQ_STARVED_BIT = 0;
	localparam int unsigned IRQ_FLAG_BIT = 1;

	// Writable bits of each register
	localparam logic [7:0] CMD_WRITE_MASK = 8'hF8;
	localparam logic [7:0] FN_WRITE_MASK = 8'hFF;
	localparam logic [7:0] POL_WRITE_MASK = 8'h3F;
	localparam logic [7:0] BRD_WRITE_MASK = 8'h01;
	localparam logic [7:0] IRQ_WRITE_MASK = 8'h03;

	// Values after reset
	localparam logic [7:0] REG_RESET = 8'h00;

	typedef struct packed {
		logic synth_enable;
		logic clock_source_select;
		logic synth_code_high;
		logic synth_code_mid;
	} synth_ctl_t;

	typedef struct packed {
		logic [1:0]  rxclk_sync;
		logic [1:0]  dnr_sync;
		logic [1:0]  odv_sync;
		logic [3:0]  flag_s1;
		logic [3:0]  flag_s2;
		logic        rxclk_prev;
		logic        odv_prev;
		logic [3:0]  flag_sampled;
		logic [3:0]  flag_prev;
		logic [7:0]  command;
		logic [7:0]  function_outputs;
		logic [7:0]  polarity;
		logic [7:0]  board_cfg;
		logic [7:0]  irq_status;
		logic [7:0]  irq_mask;
		logic [3:0]  flag_events;
		logic        out_fifo_starved;
		logic        flag_irq_prev;
		logic        pend;
		logic        pend_write;
		logic        pend_hit;
		logic [2:0]  pend_idx;
		logic        hreadyout;
		logic        hresp;
		logic [31:0] hrdata;
		logic        irq;
		logic [3:0]  user_ctl;
		synth_ctl_t  synth;
		logic        drive_inhibit;
	} regs_t;

	localparam regs_t REGS_RESET = '{hreadyout: 1'b1, default: '0};

endpackage

// *** status_interrupt_regs.sv ***
/*
 Status and interrupt register bank of the user interface: FIFO state flags,
 function outputs, sampled user flags with edge events, polarity and enables,
 and an AHB-Lite slave giving software access.
 Assumes a single AHB-Lite master; FIFO empty levels come from logic on clk;
 pins and the receive clock are asynchronous and are synchronised here.
*/
// How it works
// - Output FIFO running dry sets sticky starved flag
// - Starved flag cleared only by a write that changes interface enable
// - Status bit 1 shows input FIFO not empty
// - Status bit 0 shows output FIFO not empty
// - Function bits 0-3 drive user control outputs
// - Function bit 7 switches synthesiser on
// - Function bits 6-4 act only on earlier variant
// - Flag register low bits show sampled flags
// - Event interrupts need board and per-flag enable
// - Event set on polarity-selected flag transition
// - Clearing per-flag enable clears its event
// - Polarity zero selects rising flag change
// - Polarity one selects falling flag change
// - Global enable gates flag interrupts, keeps events
// - Polarity bit 5 enables drive inhibit on earlier variant only
// - Command bits 4-7 are per-flag enables
// - Toggling interface enable clears sticky starved flag
`timescale 1ns/1ps
module status_interrupt_regs #(
	parameter bit LATER_VARIANT = 1'b0
) (
	// Clock and reset
	input  wire logic                                    clk,
	input  wire logic                                    sys_rst,
	// AHB-Lite slave
	input  wire logic                                    hsel,
	input  wire logic [31:0]                             haddr,
	input  wire logic [1:0]                              htrans,
	input  wire logic                                    hwrite,
	input  wire logic [2:0]                              hsize,
	input  wire logic [31:0]                             hwdata,
	input  wire logic                                    hready,
	output logic [31:0]                                  hrdata,
	output logic                                         hreadyout,
	output logic                                         hresp,
	// FIFO state from the datapath
	input  wire logic                                    in_fifo_empty,
	input  wire logic                                    out_fifo_empty,
	// Link pins
	input  wire logic                                    output_word_valid,
	input  wire logic                                    downstream_not_ready,
	input  wire logic                                    receive_clock,
	input  wire logic [3:0]                              user_flag_inputs,
	// Control outputs
	output logic [3:0]                                   user_control_outputs,
	output status_interrupt_regs_pkg::synth_ctl_t        synth_ctl,
	output logic                                         drive_inhibit,
	output logic                                         irq
);

	status_interrupt_regs_pkg::regs_t r;
	status_interrupt_regs_pkg::regs_t next_r;

	logic       rx_rise;
	logic       odv_fall;
	logic       starved_set;
	logic       iface_toggle;
	logic       flag_irq;
	logic [3:0] flag_edge;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [7:0] irq_set;

	// Byte visible at a register index
	function automatic logic [7:0] read_reg(
		input status_interrupt_regs_pkg::regs_t s,
		input logic                             hit,
		input logic [2:0]                       idx,
		input logic                             in_empty,
		input logic                             out_empty
	);
		logic [7:0] v;
		v = 8'h00;
		if (!hit)
			v = 8'h00;
		else if (idx == status_interrupt_regs_pkg::IDX_COMMAND)
			v = s.command;
		else if (idx == status_interrupt_regs_pkg::IDX_DATAPATH_STATE)
		begin
			v[status_interrupt_regs_pkg::DP_STARVED_BIT] = s.out_fifo_starved;
			v[status_interrupt_regs_pkg::DP_IN_DATA_BIT] = ~in_empty;
			v[status_interrupt_regs_pkg::DP_OUT_DATA_BIT] = ~out_empty;
		end
		else if (idx == status_interrupt_regs_pkg::IDX_FUNCTION)
			v = s.function_outputs;
		else if (idx == status_interrupt_regs_pkg::IDX_FLAG_EVENTS)
			v = {s.flag_events, s.flag_sampled};
		else if (idx == status_interrupt_regs_pkg::IDX_POLARITY)
			v = s.polarity;
		else if (idx == status_interrupt_regs_pkg::IDX_BOARD_CFG)
			v = s.board_cfg;
		else if (idx == status_interrupt_regs_pkg::IDX_IRQ_STATUS)
			v = s.irq_status;
		else if (idx == status_interrupt_regs_pkg::IDX_IRQ_MASK)
			v = s.irq_mask;
		return v;
	endfunction

	// Masked merge of a written byte
	function automatic logic [7:0] merge(
		input logic [7:0] data,
		input logic [7:0] mask
	);
		return data & mask;
	endfunction

	always_comb
	begin
		next_r = r;
		wdata = hwdata[7:0];
		rdata = 8'h00;
		irq_set = 8'h00;

		// Two-flop synchronisers for pins and the receive clock
		next_r.rxclk_sync = {r.rxclk_sync[0], receive_clock};
		next_r.dnr_sync = {r.dnr_sync[0], downstream_not_ready};
		next_r.odv_sync = {r.odv_sync[0], output_word_valid};
		next_r.flag_s1 = user_flag_inputs;
		next_r.flag_s2 = r.flag_s1;

		// Flags sampled on each receive clock rising edge
		rx_rise = r.rxclk_sync[1] & ~r.rxclk_prev;
		next_r.rxclk_prev = r.rxclk_sync[1];
		if (rx_rise)
			next_r.flag_sampled = r.flag_s2;
		next_r.flag_prev = r.flag_sampled;

		// Bus data phase: one wait state, then answer
		iface_toggle = 1'b0;
		if (r.pend)
		begin
			next_r.pend = 1'b0;
			next_r.hreadyout = 1'b1;
			if (r.pend_write)
			begin
				next_r.hrdata = 32'h0000_0000;
				if (!r.pend_hit)
					next_r.hrdata = 32'h0000_0000;
				else if (r.pend_idx == status_interrupt_regs_pkg::IDX_COMMAND)
				begin
					next_r.command = merge(wdata, status_interrupt_regs_pkg::CMD_WRITE_MASK);
					iface_toggle = wdata[status_interrupt_regs_pkg::CMD_IFACE_EN_BIT]
						^ r.command[status_interrupt_regs_pkg::CMD_IFACE_EN_BIT];
				end
				else if (r.pend_idx == status_interrupt_regs_pkg::IDX_FUNCTION)
					next_r.function_outputs = merge(wdata, status_interrupt_regs_pkg::FN_WRITE_MASK);
				else if (r.pend_idx == status_interrupt_regs_pkg::IDX_POLARITY)
					next_r.polarity = merge(wdata, status_interrupt_regs_pkg::POL_WRITE_MASK);
				else if (r.pend_idx == status_interrupt_regs_pkg::IDX_BOARD_CFG)
					next_r.board_cfg = merge(wdata, status_interrupt_regs_pkg::BRD_WRITE_MASK);
				else if (r.pend_idx == status_interrupt_regs_pkg::IDX_IRQ_MASK)
					next_r.irq_mask = merge(wdata, status_interrupt_regs_pkg::IRQ_WRITE_MASK);
			end
			else
			begin
				rdata = read_reg(r, r.pend_hit, r.pend_idx, in_fifo_empty, out_fifo_empty);
				next_r.hrdata = {24'h00_0000, rdata};
			end
		end
		else if (hsel && htrans[1] && hready)
		begin
			next_r.pend = 1'b1;
			next_r.pend_write = hwrite;
			next_r.pend_idx = haddr[4:2];
			next_r.pend_hit = (haddr[31:5] == 27'h000_0000) && (haddr[1:0] == 2'h0);
			next_r.hreadyout = 1'b0;
		end

		// Sticky starved flag; a set in the clearing cycle wins
		odv_fall = r.odv_prev & ~r.odv_sync[1];
		next_r.odv_prev = r.odv_sync[1];
		starved_set = odv_fall & ~r.dnr_sync[1] & out_fifo_empty
			& r.command[status_interrupt_regs_pkg::CMD_IFACE_EN_BIT];
		next_r.out_fifo_starved = (r.out_fifo_starved & ~iface_toggle) | starved_set;

		// Flag events by polarity and per-flag enable
		for (int i = 0; i < 4; i++)
		begin
			flag_edge[i] = r.polarity[i]
				? (r.flag_prev[i] & ~r.flag_sampled[i])
				: (~r.flag_prev[i] & r.flag_sampled[i]);
			if (!next_r.command[status_interrupt_regs_pkg::CMD_FLAG_EN_LSB + i])
				next_r.flag_events[i] = 1'b0;
			else if (flag_edge[i])
				next_r.flag_events[i] = 1'b1;
		end

		// Flag interrupt request gated by per-flag, global and board enables
		flag_irq = (|(r.flag_events & r.command[7:4]))
			& r.polarity[status_interrupt_regs_pkg::POL_GLOBAL_EN_BIT]
			& r.board_cfg[status_interrupt_regs_pkg::BRD_IRQ_EN_BIT];
		next_r.flag_irq_prev = flag_irq;

		// Sticky interrupt status, cleared by its read, set wins
		irq_set[status_interrupt_regs_pkg::IRQ_STARVED_BIT] = starved_set;
		irq_set[status_interrupt_regs_pkg::IRQ_FLAG_BIT] = flag_irq & ~r.flag_irq_prev;
		if (r.pend && !r.pend_write && r.pend_hit && r.pend_idx == status_interrupt_regs_pkg::IDX_IRQ_STATUS)
			next_r.irq_status = (r.irq_status & ~rdata) | irq_set;
		else
			next_r.irq_status = r.irq_status | irq_set;
		next_r.irq = flag_irq | (|(r.irq_status & r.irq_mask));

		// Registered control outputs
		next_r.user_ctl = next_r.function_outputs[3:0];
		next_r.synth.synth_enable = next_r.function_outputs[status_interrupt_regs_pkg::FN_SYNTH_EN_BIT];
		next_r.synth.clock_source_select = ~LATER_VARIANT
			& next_r.function_outputs[status_interrupt_regs_pkg::FN_SRC_SEL_BIT];
		next_r.synth.synth_code_high = ~LATER_VARIANT
			& next_r.function_outputs[status_interrupt_regs_pkg::FN_CODE_HIGH_BIT];
		next_r.synth.synth_code_mid = ~LATER_VARIANT
			& next_r.function_outputs[status_interrupt_regs_pkg::FN_CODE_MID_BIT];
		next_r.drive_inhibit = ~LATER_VARIANT
			& next_r.polarity[status_interrupt_regs_pkg::POL_INHIBIT_BIT];
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			r <= status_interrupt_regs_pkg::REGS_RESET;
		else
			r <= next_r;
	end

	assign hrdata = r.hrdata;
	assign hreadyout = r.hreadyout;
	assign hresp = r.hresp;
	assign user_control_outputs = r.user_ctl;
	assign synth_ctl = r.synth;
	assign drive_inhibit = r.drive_inhibit;
	assign irq = r.irq;

endmodule

// *** status_interrupt_regs_assertions.sv ***
/*
 Checker for the status and interrupt register bank, bound to its ports.
 Assumes LATER_VARIANT is 0 and a single AHB-Lite master.
*/
`timescale 1ns/1ps
module status_interrupt_regs_checker (
	// Clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	// Datapath and pins
	input wire logic        in_fifo_empty,
	input wire logic        out_fifo_empty,
	input wire logic [3:0]  user_control_outputs,
	input wire logic        drive_inhibit,
	input wire logic        irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	logic       acc;
	logic       wr_fn;
	logic [1:0] empties;
	assign acc = hsel && htrans[1] && hready;
	assign wr_fn = acc && hwrite && haddr == 32'h8;
	assign empties = {in_fifo_empty, out_fifo_empty};
	a_one_wait: assert property (acc |=> !hreadyout ##1 hreadyout)
		else $error("wait state not exactly one cycle");
	a_stall_cause: assert property (!hreadyout |-> $past(acc))
		else $error("stall without a transfer");
	a_ctl_follows: assert property (wr_fn |=> ##1 user_control_outputs == $past(hwdata[3:0]))
		else $error("control outputs differ from written value");
	a_ctl_hold: assert property ($changed(user_control_outputs) |-> $past(wr_fn, 2))
		else $error("control outputs changed without a write");
	a_inhibit_follows: assert property (acc && hwrite && haddr == 32'h10 |=> ##1 drive_inhibit == $past(hwdata[5]))
		else $error("drive inhibit differs from written bit");
	a_fifo_state: assert property (acc && !hwrite && haddr == 32'h4 |=> ##1 hrdata[1:0] == ~$past(empties))
		else $error("fifo state bits wrong");
	a_upper_zero: assert property ($rose(hreadyout) |-> hrdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_unmapped_zero: assert property (acc && !hwrite && haddr[31:5] != 27'h0 |=> ##1 hrdata == 32'h0)
		else $error("unmapped read not zero");
	c_flag_read: cover property (acc && !hwrite && haddr == 32'hC);
	c_irq_rise: cover property ($rose(irq));
	c_fn_write: cover property (wr_fn);
endmodule

bind status_interrupt_regs status_interrupt_regs_checker i_chk (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hrdata, .hreadyout, .in_fifo_empty, .out_fifo_empty, .user_control_outputs, .drive_inhibit, .irq);

// *** status_interrupt_regs_far.sv ***
/*
 Model of the external user device on the link pins.
 Assumes the bench calls its tasks; the receive clock runs only in bursts.
*/
`timescale 1ns/1ps
module status_interrupt_regs_far (
	// Link pins toward the bank
	output logic       receive_clock,
	output logic [3:0] user_flag_inputs,
	output logic       output_word_valid,
	output logic       downstream_not_ready
);
	initial
	begin
		receive_clock = 1'b0;
		user_flag_inputs = 4'h0;
		output_word_valid = 1'b0;
		downstream_not_ready = 1'b1;
	end
	// Present flags, then clock them in with a short burst
	task automatic send(input logic [3:0] f);
		user_flag_inputs = f;
		repeat (3)
		begin
			#160 receive_clock = 1'b1;
			#160 receive_clock = 1'b0;
		end
	endtask
	// Stream ends while downstream is ready
	task automatic drain;
		downstream_not_ready = 1'b0;
		output_word_valid = 1'b1;
		#640 output_word_valid = 1'b0;
		#640 downstream_not_ready = 1'b1;
	endtask
endmodule

// *** status_interrupt_regs_tb_top.sv ***
/*
 Self-checking bench for the status and interrupt register bank.
 Assumes the far-side model drives the link pins; clock 25 MHz.
*/
`timescale 1ns/1ps
module status_interrupt_regs_tb_top;
	typedef struct packed {
		logic [7:0] a;
		logic       w;
		logic [7:0] d;
		logic [7:0] e;
	} row_t;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        hsel = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        in_fifo_empty = 1'b0;
	logic        out_fifo_empty = 1'b1;
	logic [31:0] hrdata;
	logic        hreadyout, receive_clock, output_word_valid, downstream_not_ready, drive_inhibit, irq;
	logic [3:0]  user_flag_inputs, user_control_outputs, synth_bits;
	logic [7:0]  q;
	int          fails = 0;
	int          checked = 0;
	row_t        rows [9] = '{'{8'h08, 1'b0, 8'h00, 8'h00}, '{8'h08, 1'b1, 8'hA5, 8'hA5}, '{8'h10, 1'b1, 8'hFF, 8'h3F},
		'{8'h14, 1'b1, 8'hFF, 8'h01}, '{8'h1C, 1'b1, 8'hFF, 8'h03}, '{8'h00, 1'b1, 8'hFF, 8'hF8},
		'{8'h04, 1'b1, 8'hFF, 8'h02}, '{8'h0C, 1'b1, 8'hFF, 8'h00}, '{8'h20, 1'b1, 8'hFF, 8'h00}};
	always #20 clk = ~clk;
	status_interrupt_regs i_dut (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp(), .in_fifo_empty, .out_fifo_empty, .output_word_valid,
		.downstream_not_ready, .receive_clock, .user_flag_inputs, .user_control_outputs, .synth_ctl(synth_bits),
		.drive_inhibit, .irq);
	status_interrupt_regs_far i_far (.receive_clock, .user_flag_inputs, .output_word_valid, .downstream_not_ready);
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		checked++;
		if (s !== e)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge clk);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata[7:0];
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		xfer(a, 1'b0, 8'h00);
		chk("read data", e, q);
	endtask
	task automatic gap;
		repeat (3) @(posedge clk);
	endtask
	task automatic irq_is(input logic e);
		gap;
		chk("irq", {7'h0, e}, {7'h0, irq});
	endtask
	task automatic wrap_up;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		irq_is(1'b0);
		foreach (rows[i])
		begin
			if (rows[i].w)
				xfer(rows[i].a, 1'b1, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		gap;
		chk("user_control_outputs", 8'h05, {4'h0, user_control_outputs});
		chk("synth_ctl", 8'h0A, {4'h0, synth_bits});
		chk("drive_inhibit", 8'h01, {7'h0, drive_inhibit});
		in_fifo_empty <= 1'b1;
		out_fifo_empty <= 1'b0;
		rd(8'h04, 8'h01);
		in_fifo_empty <= 1'b0;
		out_fifo_empty <= 1'b1;
		i_far.send(4'hF);
		gap;
		rd(8'h0C, 8'h0F);
		i_far.send(4'h0);
		gap;
		rd(8'h0C, 8'hF0);
		irq_is(1'b1);
		xfer(8'h10, 1'b1, 8'h20);
		rd(8'h18, 8'h02);
		irq_is(1'b0);
		rd(8'h0C, 8'hF0);
		xfer(8'h00, 1'b1, 8'h08);
		rd(8'h0C, 8'h00);
		xfer(8'h00, 1'b1, 8'hF8);
		xfer(8'h10, 1'b1, 8'h10);
		i_far.send(4'h5);
		gap;
		rd(8'h0C, 8'h55);
		rd(8'h18, 8'h02);
		i_far.drain;
		gap;
		rd(8'h04, 8'h06);
		rd(8'h04, 8'h06);
		rd(8'h18, 8'h01);
		xfer(8'h00, 1'b1, 8'h00);
		rd(8'h04, 8'h02);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		irq_is(1'b0);
		chk("user_control_outputs", 8'h00, {4'h0, user_control_outputs});
		rd(8'h08, 8'h00);
		wrap_up;
	end
	initial
	begin
		#200000;
		fails++;
		wrap_up;
	end
endmodule
